// ### hw/eisa_bridge_decode_irq.sv
`timescale 1ns/1ps
module eisa_bridge_decode_irq
(
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire eisa_bridge_pkg::io_req_t I_PCI_IO,
    input wire logic I_DEVSEL_SEEN,
    output logic O_SUB_CLAIM,
    output eisa_bridge_pkg::region_t O_REGION,
    output logic [3:0] O_SLOT,
    input wire eisa_bridge_pkg::cpu_req_t I_CPU_IO,
    output logic O_CPU_HIT,
    output logic [31:0] O_CPU_PCI_ADDR,
    input wire eisa_bridge_pkg::io_req_t I_EISA_CYC,
    input wire logic I_HOLE_EN,
    input wire logic [31:0] I_HOLE_LO,
    input wire logic [31:0] I_HOLE_HI,
    output logic O_EISA_TO_PCI,
    output logic O_EISA_LOCAL,
    input wire logic I_LB_IN_VALID,
    output logic O_LB_IN_READY,
    input wire eisa_bridge_pkg::lb_entry_t I_LB_IN,
    output logic O_LB_OUT_VALID,
    input wire logic I_LB_OUT_READY,
    output eisa_bridge_pkg::lb_entry_t O_LB_OUT,
    input wire logic [31:0] I_SLAVE_IRQ,
    input wire logic I_TIMER_IRQ,
    input wire logic I_PASSIVE_REL,
    input wire logic I_NMI,
    input wire logic I_ENET_IRQ,
    input wire logic [31:0] I_SLAVE_MASK,
    input wire logic [7:0] I_MASTER_MASK,
    input wire logic I_EOI,
    output logic [eisa_bridge_pkg::HOST_PINS-1:0] O_HOST_INTR,
    input wire logic I_INTERRUPT_ACK_READ_REQ,
    output logic O_INTERRUPT_ACK_READ_PULSE,
    output logic O_INTERRUPT_ACK_READ_DONE,
    output logic [7:0] O_INTERRUPT_ACK_READ_VECTOR,
    output logic [7:0] O_MASTER_ISR
);
    // ==========================================================
    // state
    typedef struct packed
    {
        eisa_bridge_pkg::ack_state_t ack;
        logic [35:0] irq_meta;
        logic [35:0] irq_pin;
        logic [eisa_bridge_pkg::LB_DEPTH-1:0][$bits(eisa_bridge_pkg::lb_entry_t)-1:0] lb;
        logic [1:0] wr;
        logic [1:0] rd;
        logic [2:0] cnt;
        logic claim;
        eisa_bridge_pkg::region_t region;
        logic [3:0] slot;
        logic cpu_hit;
        logic [31:0] cpu_pci;
        logic eisa_fwd;
        logic eisa_local;
        logic [eisa_bridge_pkg::HOST_PINS-1:0] host;
        logic [7:0] master_isr;
        logic [eisa_bridge_pkg::SLAVES-1:0][7:0] slave_isr;
        logic [7:0] vector;
        logic done;
    } state_t;

    state_t st;
    state_t next_st;

    logic [eisa_bridge_pkg::SLAVES-1:0][7:0] slave_pend;
    logic [7:0] master_req;
    logic [7:0] master_pend;
    logic [31:0] slave_raw;
    eisa_bridge_pkg::lb_entry_t head;
    logic push;
    logic pop;

    assign slave_raw = st.irq_pin[31:0];
    assign head = eisa_bridge_pkg::lb_entry_t'(st.lb[st.rd]);

    // ==========================================================
    // controller tree, level requests after the synchroniser
    always_comb
    begin
        for (int s = 0; s < eisa_bridge_pkg::SLAVES; s++)
            slave_pend[s] = slave_raw[8*s +: 8] & ~I_SLAVE_MASK[8*s +: 8];
        master_req = 8'h00;
        master_req[eisa_bridge_pkg::ML_TIMER] = st.irq_pin[32];
        master_req[1] = |slave_pend[0];
        master_req[3] = |slave_pend[1];
        master_req[4] = |slave_pend[2];
        master_req[5] = |slave_pend[3];
        master_req[eisa_bridge_pkg::ML_PASSIVE] = st.irq_pin[33];
    end
    assign master_pend = master_req & ~I_MASTER_MASK;

    // ==========================================================
    // line buffers: one ordered queue for both directions
    // a direction change waits for the queue to drain, so a read return
    // can never pass an older write; costs a bubble per turnaround
    always_comb
    begin
        O_LB_IN_READY = (st.cnt != eisa_bridge_pkg::LB_FULL)
            && (st.ack == eisa_bridge_pkg::ACK_IDLE)
            && (st.cnt == 3'h0 || head.to_pci == I_LB_IN.to_pci);
    end
    assign O_LB_OUT_VALID = (st.cnt != 3'h0);
    assign O_LB_OUT = head;
    assign push = I_LB_IN_VALID && O_LB_IN_READY;
    assign pop = O_LB_OUT_VALID && I_LB_OUT_READY;

    // ==========================================================
    // next state
    always_comb
    begin
        logic [3:0] mp;
        logic [3:0] sp;
        logic [2:0] cs;
        logic [7:0] set_m;
        logic [eisa_bridge_pkg::SLAVES-1:0][7:0] set_s;
        mp = eisa_bridge_pkg::prio8(master_pend);
        cs = eisa_bridge_pkg::casc(mp[2:0]);
        sp = eisa_bridge_pkg::prio8(slave_pend[cs[1:0]]);
        set_m = 8'h00;
        set_s = '0;
        next_st = st;
        next_st.irq_meta = {I_ENET_IRQ, I_NMI, I_PASSIVE_REL, I_TIMER_IRQ, I_SLAVE_IRQ};
        next_st.irq_pin = st.irq_meta;
        next_st.done = 1'b0;

        // pci i/o decode
        next_st.claim = I_PCI_IO.valid && (I_PCI_IO.addr < eisa_bridge_pkg::SUBTR_LIMIT)
            && !I_DEVSEL_SEEN;
        next_st.slot = 4'h0;
        if (I_PCI_IO.addr <= eisa_bridge_pkg::BRIDGE_LAST)
            next_st.region = eisa_bridge_pkg::RG_BRIDGE;
        else if (I_PCI_IO.addr <= eisa_bridge_pkg::SLOT_LAST)
        begin
            next_st.region = eisa_bridge_pkg::RG_SLOT;
            next_st.slot = I_PCI_IO.addr[eisa_bridge_pkg::SLOT_LSB +: 4];
        end
        else if (I_PCI_IO.addr <= eisa_bridge_pkg::FREE_LAST)
            next_st.region = eisa_bridge_pkg::RG_FREE;
        else if (I_PCI_IO.addr <= eisa_bridge_pkg::FSPARSE_LAST)
            next_st.region = eisa_bridge_pkg::RG_FSPARSE;
        else if (I_PCI_IO.addr <= eisa_bridge_pkg::VSPARSE_LAST)
            next_st.region = eisa_bridge_pkg::RG_VSPARSE;
        else
            next_st.region = eisa_bridge_pkg::RG_NONE;

        // cpu window to pci i/o, five address bits carry length
        next_st.cpu_hit = I_CPU_IO.valid && (I_CPU_IO.addr >= eisa_bridge_pkg::CPU_IO_BASE)
            && (I_CPU_IO.addr <= eisa_bridge_pkg::CPU_IO_LAST);
        next_st.cpu_pci = 32'((I_CPU_IO.addr - eisa_bridge_pkg::CPU_IO_BASE)
            >> eisa_bridge_pkg::CPU_SHIFT);

        // eisa originated cycles
        next_st.eisa_fwd = I_EISA_CYC.valid
            && !(I_EISA_CYC.addr >= eisa_bridge_pkg::EISA_HOLE_LO
                && I_EISA_CYC.addr < eisa_bridge_pkg::EISA_HOLE_HI)
            && !(I_HOLE_EN && I_EISA_CYC.addr >= I_HOLE_LO
                && I_EISA_CYC.addr < I_HOLE_HI);
        next_st.eisa_local = I_EISA_CYC.valid && !next_st.eisa_fwd;

        // line buffer pointers
        if (push)
        begin
            next_st.lb[st.wr] = I_LB_IN;
            next_st.wr = st.wr + 2'h1;
        end
        if (pop)
            next_st.rd = st.rd + 2'h1;
        next_st.cnt = 3'(st.cnt + {2'h0, push} - {2'h0, pop});

        // host pins
        next_st.host = '0;
        next_st.host[eisa_bridge_pkg::HP_NMI] = st.irq_pin[34];
        next_st.host[eisa_bridge_pkg::HP_DEV] = |master_pend;
        next_st.host[eisa_bridge_pkg::HP_ENET] = st.irq_pin[35];

        // acknowledge sequence
        unique case (st.ack)
            eisa_bridge_pkg::ACK_IDLE:
                if (I_INTERRUPT_ACK_READ_REQ)
                    next_st.ack = eisa_bridge_pkg::ACK_FLUSH;
            eisa_bridge_pkg::ACK_FLUSH:
                if (st.cnt == 3'h0)
                    next_st.ack = eisa_bridge_pkg::ACK_PULSE1;
            eisa_bridge_pkg::ACK_PULSE1:
            begin
                next_st.ack = eisa_bridge_pkg::ACK_GAP;
                if (!mp[3] || mp[2:0] == eisa_bridge_pkg::ML_PASSIVE)
                    next_st.vector = eisa_bridge_pkg::MASTER_VEC_BASE
                        + {5'h00, eisa_bridge_pkg::ML_PASSIVE};
                else if (cs[2])
                begin
                    next_st.vector = eisa_bridge_pkg::SLAVE_VEC_BASE
                        + {3'h0, cs[1:0], sp[2:0]};
                    set_m[mp[2:0]] = 1'b1;
                    set_s[cs[1:0]][sp[2:0]] = sp[3];
                end
                else
                begin
                    next_st.vector = eisa_bridge_pkg::MASTER_VEC_BASE + {5'h00, mp[2:0]};
                    set_m[mp[2:0]] = 1'b1;
                end
            end
            eisa_bridge_pkg::ACK_GAP:
                next_st.ack = eisa_bridge_pkg::ACK_PULSE2;
            eisa_bridge_pkg::ACK_PULSE2:
            begin
                next_st.ack = eisa_bridge_pkg::ACK_IDLE;
                next_st.done = 1'b1;
            end
            default:
                next_st.ack = eisa_bridge_pkg::ACK_IDLE;
        endcase

        // an acknowledge landing with end of interrupt keeps its bit
        next_st.master_isr = (I_EOI ? 8'h00 : st.master_isr) | set_m;
        next_st.slave_isr = (I_EOI ? '0 : st.slave_isr) | set_s;
    end

    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESET_N)
            st <= '0;
        else
            st <= next_st;
    end

    // ==========================================================
    // outputs
    assign O_SUB_CLAIM = st.claim;
    assign O_REGION = st.region;
    assign O_SLOT = st.slot;
    assign O_CPU_HIT = st.cpu_hit;
    assign O_CPU_PCI_ADDR = st.cpu_pci;
    assign O_EISA_TO_PCI = st.eisa_fwd;
    assign O_EISA_LOCAL = st.eisa_local;
    assign O_HOST_INTR = st.host;
    assign O_INTERRUPT_ACK_READ_PULSE = (st.ack == eisa_bridge_pkg::ACK_PULSE1)
        || (st.ack == eisa_bridge_pkg::ACK_PULSE2);
    assign O_INTERRUPT_ACK_READ_DONE = st.done;
    assign O_INTERRUPT_ACK_READ_VECTOR = st.vector;
    assign O_MASTER_ISR = st.master_isr;

    // ==========================================================
    // checks
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);

    sequence two_pulses;
        O_INTERRUPT_ACK_READ_PULSE ##1 !O_INTERRUPT_ACK_READ_PULSE ##1 O_INTERRUPT_ACK_READ_PULSE ##1 !O_INTERRUPT_ACK_READ_PULSE;
    endsequence

    a_sub_claim_low: assert property (
        I_PCI_IO.valid && I_PCI_IO.addr < 32'h0001_0000 && !I_DEVSEL_SEEN |=> O_SUB_CLAIM)
        else $error("unclaimed low i/o not taken");
    a_no_claim_high: assert property (
        I_PCI_IO.valid && I_PCI_IO.addr[31:16] != 16'h0000 |=> !O_SUB_CLAIM)
        else $error("claim above 64 Kbytes");
    a_cpu_sparse_map: assert property (
        O_CPU_HIT |-> O_CPU_PCI_ADDR == 32'($past(I_CPU_IO.addr[31:0]) >> 5))
        else $error("cpu to pci address wrong");
    a_slot_select: assert property (
        I_PCI_IO.addr >= 32'h0000_1000 && I_PCI_IO.addr <= 32'h0000_8FFF
        |=> O_REGION == eisa_bridge_pkg::RG_SLOT && O_SLOT == $past(I_PCI_IO.addr[15:12]))
        else $error("slot decode wrong");
    a_eisa_fixed_hole: assert property (
        I_EISA_CYC.valid && I_EISA_CYC.addr >= 32'h0008_0000 && I_EISA_CYC.addr < 32'h0010_0000
        |=> O_EISA_LOCAL && !O_EISA_TO_PCI)
        else $error("fixed hole forwarded");
    a_lb_no_overfill: assert property (
        st.cnt == 3'h4 |-> !O_LB_IN_READY)
        else $error("line buffer overfilled");
    a_interrupt_ack_read_after_flush: assert property (
        $rose(O_INTERRUPT_ACK_READ_PULSE) |-> st.cnt == 3'h0 && !$past(push))
        else $error("acknowledge before drain");
    a_interrupt_ack_read_two_pulses: assert property (
        $rose(O_INTERRUPT_ACK_READ_PULSE) && st.ack == eisa_bridge_pkg::ACK_PULSE1
        |-> two_pulses ##0 O_INTERRUPT_ACK_READ_DONE)
        else $error("acknowledge pulse pair wrong");
    a_host_line_held: assert property (
        |master_pend |=> O_HOST_INTR[1])
        else $error("pending interrupt not on host pin");
    a_passive_no_isr: assert property (
        st.ack == eisa_bridge_pkg::ACK_PULSE1 && master_pend == 8'h80 && !I_EOI
        |=> O_MASTER_ISR == $past(O_MASTER_ISR))
        else $error("passive release set in-service bit");
endmodule // eisa_bridge_decode_irq

// ### hw/eisa_bridge_pkg.sv
package eisa_bridge_pkg;
    // ==========================================================
    // line buffers
    localparam int LB_DEPTH = 4;
    localparam int LB_BYTES = 16;
    localparam int LB_DATA_W = LB_BYTES * 8;
    localparam logic [2:0] LB_FULL = 3'h4;
    // ==========================================================
    // pci i/o map, byte addresses
    localparam logic [31:0] SUBTR_LIMIT = 32'h0001_0000;
    localparam logic [31:0] BRIDGE_LAST = 32'h0000_0FFF;
    localparam logic [31:0] SLOT_LAST = 32'h0000_8FFF;
    localparam logic [31:0] FREE_LAST = 32'h0000_FFFF;
    localparam logic [31:0] FSPARSE_LAST = 32'h00FF_FFFF;
    localparam logic [31:0] VSPARSE_LAST = 32'h07FF_FFFF;
    localparam int SLOT_LSB = 12;
    // ==========================================================
    // cpu i/o window, sparse by 32
    localparam logic [35:0] CPU_IO_BASE = 36'h2_0000_0000;
    localparam logic [35:0] CPU_IO_LAST = 36'h2_FFFF_FFFF;
    localparam int CPU_SHIFT = 5;
    // ==========================================================
    // eisa fixed local hole, upper bound exclusive
    localparam logic [31:0] EISA_HOLE_LO = 32'h0008_0000;
    localparam logic [31:0] EISA_HOLE_HI = 32'h0010_0000;
    // ==========================================================
    // controller tree
    localparam int SLAVES = 4;
    localparam logic [2:0] ML_TIMER = 3'h0;
    localparam logic [2:0] ML_PASSIVE = 3'h7;
    localparam logic [7:0] MASTER_VEC_BASE = 8'h00;
    localparam logic [7:0] SLAVE_VEC_BASE = 8'h08;
    localparam int HOST_PINS = 5;
    localparam int HP_NMI = 0;
    localparam int HP_DEV = 1;
    localparam int HP_ENET = 4;

    typedef enum logic [2:0]
    {
        ACK_IDLE = 3'h0,
        ACK_FLUSH = 3'h1,
        ACK_PULSE1 = 3'h3,
        ACK_GAP = 3'h2,
        ACK_PULSE2 = 3'h6
    } ack_state_t;

    typedef enum logic [2:0]
    {
        RG_BRIDGE = 3'h0,
        RG_SLOT = 3'h1,
        RG_FREE = 3'h2,
        RG_FSPARSE = 3'h3,
        RG_VSPARSE = 3'h4,
        RG_NONE = 3'h5
    } region_t;

    typedef struct packed {logic valid; logic write; logic [31:0] addr;} io_req_t;
    typedef struct packed {logic valid; logic [35:0] addr;} cpu_req_t;
    typedef struct packed {logic to_pci; logic [31:0] addr; logic [LB_DATA_W-1:0] data;} lb_entry_t;

    // {found, index} of the lowest set bit: line 0 wins
    function automatic logic [3:0] prio8(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
                r = {1'b1, 3'(i)};
        end
        return r;
    endfunction

    // {is cascade, slave number} for a master line
    function automatic logic [2:0] casc(input logic [2:0] line);
        case (line)
            3'h1: casc = 3'h4;
            3'h3: casc = 3'h5;
            3'h4: casc = 3'h6;
            3'h5: casc = 3'h7;
            default: casc = 3'h0;
        endcase
    endfunction
endpackage

// ### sim/eisa_bridge_decode_irq_test.sv
`timescale 1ns/1ps
module eisa_bridge_decode_irq_test;
    logic clk, rst_n, devsel, hole_en, lb_in_valid, lb_out_ready, stall;
    logic timer, passive, nmi, enet, eoi, interrupt_ack_read_req;
    logic [31:0] hole_lo, hole_hi, slave_irq, slave_mask;
    logic [7:0] master_mask;
    eisa_bridge_pkg::io_req_t pci, eisa;
    eisa_bridge_pkg::cpu_req_t cpu;
    eisa_bridge_pkg::lb_entry_t lb_in, o_lb_out;
    eisa_bridge_pkg::region_t o_region;
    logic o_sub_claim, o_cpu_hit, o_eisa_to_pci, o_eisa_local, o_lb_in_ready, o_lb_out_valid;
    logic o_interrupt_ack_read_pulse, o_interrupt_ack_read_done;
    logic [3:0] o_slot;
    logic [31:0] o_cpu_pci_addr;
    logic [4:0] o_host_intr;
    logic [7:0] o_interrupt_ack_read_vector, o_master_isr;
    logic [2:0] top_pin;
    int errors = 0;
    int comparisons = 0;

    eisa_bridge_decode_irq uut
    (
        .I_MCLK(clk), .I_RESET_N(rst_n), .I_PCI_IO(pci), .I_DEVSEL_SEEN(devsel),
        .O_SUB_CLAIM(o_sub_claim), .O_REGION(o_region), .O_SLOT(o_slot), .I_CPU_IO(cpu),
        .O_CPU_HIT(o_cpu_hit), .O_CPU_PCI_ADDR(o_cpu_pci_addr), .I_EISA_CYC(eisa),
        .I_HOLE_EN(hole_en), .I_HOLE_LO(hole_lo), .I_HOLE_HI(hole_hi),
        .O_EISA_TO_PCI(o_eisa_to_pci), .O_EISA_LOCAL(o_eisa_local),
        .I_LB_IN_VALID(lb_in_valid), .O_LB_IN_READY(o_lb_in_ready), .I_LB_IN(lb_in),
        .O_LB_OUT_VALID(o_lb_out_valid), .I_LB_OUT_READY(lb_out_ready), .O_LB_OUT(o_lb_out),
        .I_SLAVE_IRQ(slave_irq), .I_TIMER_IRQ(timer), .I_PASSIVE_REL(passive), .I_NMI(nmi),
        .I_ENET_IRQ(enet), .I_SLAVE_MASK(slave_mask), .I_MASTER_MASK(master_mask),
        .I_EOI(eoi), .O_HOST_INTR(o_host_intr), .I_INTERRUPT_ACK_READ_REQ(interrupt_ack_read_req),
        .O_INTERRUPT_ACK_READ_PULSE(o_interrupt_ack_read_pulse), .O_INTERRUPT_ACK_READ_DONE(o_interrupt_ack_read_done),
        .O_INTERRUPT_ACK_READ_VECTOR(o_interrupt_ack_read_vector), .O_MASTER_ISR(o_master_isr)
    );

    eisa_far_model far
    (
        .i_clk(clk), .i_stall(stall), .i_out_valid(o_lb_out_valid), .i_out(o_lb_out),
        .i_host_intr(o_host_intr), .o_ready(lb_out_ready), .o_top_pin(top_pin)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // common helpers
    task automatic tick();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic give_up();
        check(1'b0, 1'b1);
        finish_test();
    endtask
    // ==========================================================
    // decode scenarios
    task automatic pci_dec(input logic [31:0] a, input logic ds, input logic cl,
                           input logic [2:0] rg, input logic [3:0] sl);
        pci = '{valid:1'b1, write:1'b0, addr:a};
        devsel = ds;
        tick();
        check(o_sub_claim, cl);
        check(o_region, rg);
        check(o_slot, sl);
    endtask

    task automatic cpu_map(input logic [35:0] a, input logic hit, input logic [31:0] pa);
        cpu = '{valid:1'b1, addr:a};
        tick();
        check(o_cpu_hit, hit);
        if (hit)
            check(o_cpu_pci_addr, pa);
    endtask

    task automatic eisa_map(input logic [31:0] a, input logic en, input logic fwd);
        eisa = '{valid:1'b1, write:1'b1, addr:a};
        hole_en = en;
        tick();
        check(o_eisa_to_pci, fwd);
        check(o_eisa_local, !fwd);
    endtask
    // ==========================================================
    // line buffer scenarios
    task automatic push(input logic dir, input logic [127:0] d);
        int n;
        n = 0;
        lb_in = '{to_pci:dir, addr:32'h0, data:d};
        lb_in_valid = 1'b1;
        #1;
        while (o_lb_in_ready !== 1'b1 && n < 50)
        begin
            tick();
            n++;
        end
        if (n == 50)
            give_up();
        tick();
    endtask

    task automatic wait_got(input int k);
        int n;
        n = 0;
        while (far.got.size() < k && n < 50)
        begin
            tick();
            n++;
        end
        if (n == 50)
            give_up();
    endtask

    task automatic lb_fill();
        stall = 1'b1;
        for (int i = 0; i < 4; i++)
            push(1'b1, 128'(i + 'hA0));
        check(o_lb_in_ready, 1'b0);
        lb_in_valid = 1'b0;
        stall = 1'b0;
        wait_got(4);
        for (int i = 0; i < 4; i++)
            check(far.got[i].data, 128'(i + 'hA0));
    endtask

    task automatic lb_dir();
        stall = 1'b1;
        push(1'b1, 128'hB1);
        // offered with the old direction still held: must not be taken
        lb_in = '{to_pci:1'b0, addr:32'h0, data:128'hB2};
        tick();
        check(o_lb_in_ready, 1'b0);
        stall = 1'b0;
        push(1'b0, 128'hB2);
        lb_in_valid = 1'b0;
        wait_got(6);
        check(far.got[4].data, 128'hB1);
        check(far.got[5].data, 128'hB2);
    endtask
    // ==========================================================
    // interrupt scenarios
    task automatic interrupt_ack_read(input logic [7:0] vec, input logic [7:0] isr);
        int n, pulses, early;
        n = 0;
        pulses = 0;
        early = 0;
        interrupt_ack_read_req = 1'b1;
        tick();
        interrupt_ack_read_req = 1'b0;
        while (o_interrupt_ack_read_done !== 1'b1 && n < 100)
        begin
            if (o_interrupt_ack_read_pulse)
                pulses++;
            if ((o_interrupt_ack_read_pulse && o_lb_out_valid) || o_lb_in_ready)
                early++;
            tick();
            n++;
        end
        if (n == 100)
            give_up();
        check(pulses, 2);
        check(early, 0);
        check(o_interrupt_ack_read_vector, vec);
        check(o_master_isr, isr);
        eoi = 1'b1;
        tick();
        eoi = 1'b0;
        // inputs pass two sync flops and a host register
        repeat (4) tick();
    endtask

    task automatic pins();
        nmi = 1'b1;
        enet = 1'b1;
        slave_irq = 32'h0000_0400;
        repeat (4) tick();
        check(o_host_intr, 5'h13);
        check(top_pin, 3'h0);
        nmi = 1'b0;
        enet = 1'b0;
        repeat (4) tick();
        check(o_host_intr, 5'h02);
    endtask

    task automatic irq_tree();
        stall = 1'b1;
        push(1'b1, 128'hC1);
        push(1'b1, 128'hC2);
        lb_in_valid = 1'b0;
        stall = 1'b0;
        interrupt_ack_read(8'h12, 8'h08);
        check(far.got.size(), 8);
        timer = 1'b1;
        repeat (4) tick();
        interrupt_ack_read(8'h00, 8'h01);
        master_mask = 8'h01;
        interrupt_ack_read(8'h12, 8'h08);
        slave_irq = 32'h8000_0001;
        interrupt_ack_read(8'h08, 8'h02);
        slave_mask = 32'h0000_0001;
        interrupt_ack_read(8'h27, 8'h20);
        {slave_irq, timer, passive} = {32'h0, 1'b0, 1'b1};
        repeat (4) tick();
        interrupt_ack_read(8'h07, 8'h00);
    endtask

    initial
    begin
        rst_n = 1'b0;
        {devsel, hole_en, lb_in_valid, timer, passive, nmi, enet, eoi, interrupt_ack_read_req} = '0;
        stall = 1'b0;
        pci = '0;
        eisa = '0;
        cpu = '0;
        lb_in = '0;
        hole_lo = 32'h0200_0000;
        hole_hi = 32'h0300_0000;
        {slave_irq, slave_mask, master_mask} = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        tick();
        pci_dec(32'h0000_0010, 1'b0, 1'b1, 3'h0, 4'h0);
        pci_dec(32'h0000_0FFF, 1'b0, 1'b1, 3'h0, 4'h0);
        pci_dec(32'h0000_1000, 1'b0, 1'b1, 3'h1, 4'h1);
        pci_dec(32'h0000_3010, 1'b0, 1'b1, 3'h1, 4'h3);
        pci_dec(32'h0000_8FFF, 1'b0, 1'b1, 3'h1, 4'h8);
        pci_dec(32'h0000_9000, 1'b0, 1'b1, 3'h2, 4'h0);
        pci_dec(32'h0000_FFFF, 1'b1, 1'b0, 3'h2, 4'h0);
        pci_dec(32'h0001_0000, 1'b0, 1'b0, 3'h3, 4'h0);
        pci_dec(32'h00FF_FFFF, 1'b0, 1'b0, 3'h3, 4'h0);
        pci_dec(32'h0100_0000, 1'b0, 1'b0, 3'h4, 4'h0);
        pci_dec(32'h07FF_FFFF, 1'b0, 1'b0, 3'h4, 4'h0);
        pci_dec(32'h0800_0000, 1'b0, 1'b0, 3'h5, 4'h0);
        cpu_map(36'h2_0000_0000, 1'b1, 32'h0000_0000);
        cpu_map(36'h2_0001_FFFF, 1'b1, 32'h0000_0FFF);
        cpu_map(36'h2_0002_0000, 1'b1, 32'h0000_1000);
        cpu_map(36'h1_FFFF_FFFF, 1'b0, 32'h0000_0000);
        eisa_map(32'h0007_FFFF, 1'b0, 1'b1);
        eisa_map(32'h0008_0000, 1'b0, 1'b0);
        eisa_map(32'h000F_FFFF, 1'b0, 1'b0);
        eisa_map(32'h0010_0000, 1'b0, 1'b1);
        eisa_map(32'h0200_0000, 1'b1, 1'b0);
        eisa_map(32'h02FF_FFFF, 1'b1, 1'b0);
        eisa_map(32'h0300_0000, 1'b1, 1'b1);
        eisa_map(32'h0200_0000, 1'b0, 1'b1);
        lb_fill();
        lb_dir();
        pins();
        irq_tree();
        finish_test();
    end
endmodule // eisa_bridge_decode_irq_test

// ### sim/eisa_far_model.sv
`timescale 1ns/1ps
module eisa_far_model
(
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_out_valid,
    input wire eisa_bridge_pkg::lb_entry_t i_out,
    input wire logic [eisa_bridge_pkg::HOST_PINS-1:0] i_host_intr,
    output logic o_ready,
    output logic [2:0] o_top_pin
);
    eisa_bridge_pkg::lb_entry_t got[$];
    // ==========================================================
    // sink side, may stall like a slow eisa target
    always @(posedge i_clk)
        o_ready <= !i_stall;
    always @(posedge i_clk)
        if (i_out_valid && o_ready)
            got.push_back(i_out);
    // ==========================================================
    // host ranking of its interrupt pins
    always_comb
    begin
        o_top_pin = 3'h7;
        for (int i = eisa_bridge_pkg::HOST_PINS - 1; i >= 0; i--)
            if (i_host_intr[i])
                o_top_pin = 3'(i);
    end
endmodule // eisa_far_model
